// file: hw/spp_programmer.sv
// Setpoint profile programmer: sequencer, command arbiter and parameter store
`timescale 1ns/1ps
`default_nettype none
module spp_programmer #(
	parameter int TICK_CYCLES  = spp_pkg::TICK_CYCLES,
	parameter int FLASH_CYCLES = spp_pkg::FLASH_CYCLES
) (
	input  wire logic                    mclk,
	input  wire logic                    srst,
	input  wire logic signed [15:0]      process_value,
	input  wire logic signed [15:0]      normal_control_setpoint,
	input  wire logic                    comms_cmd_valid,
	input  wire spp_pkg::spp_cmd_e       comms_cmd,
	input  wire logic                    panel_cmd_valid,
	input  wire spp_pkg::spp_cmd_e       panel_cmd,
	input  wire logic                    rear_contact_closed,
	input  wire logic                    param_wr,
	input  wire logic [2:0]              param_sel,
	input  wire logic [15:0]             param_wdata,
	input  wire logic                    power_fail,
	input  wire logic                    resume_req,
	input  wire spp_pkg::spp_seg_e       resume_seg,
	input  wire logic signed [15:0]      resume_setpoint,
	input  wire logic [7:0]              resume_repeat,
	input  wire logic [13:0]             resume_dwell,
	output logic signed [15:0]           active_setpoint,
	output spp_pkg::spp_state_e          prog_state,
	output spp_pkg::spp_seg_e            prog_segment,
	output logic [7:0]                   repeat_count,
	output logic [13:0]                  first_dwell_time,
	output logic [13:0]                  second_dwell_time,
	output logic                         beacon,
	output logic                         param_refused,
	output logic                         nv_save
);
	// Whole block state
	typedef struct packed {
		spp_pkg::spp_state_e state;  // Programmer state
		spp_pkg::spp_seg_e   seg;    // Current segment
		logic signed [23:0]  acc;    // Fine setpoint accumulator
		logic signed [15:0]  sp;     // Setpoint handed to control
		logic                up;     // Ramp direction
		logic [7:0]          rep;    // Passes remaining
		logic [13:0]         dleft;  // Dwell minutes remaining
		logic [6:0]          sub;    // Ticks within the current minute
		logic [26:0]         tcnt;   // Tick divider
		logic [25:0]         fcnt;   // Flash divider
		logic                flash;  // Flash phase
		logic                beacon; // Beacon drive
		logic                refused;// Write refused last cycle
		logic                nv;     // Save strobe
		logic [13:0]         d1_show;// First dwell as shown
		logic [13:0]         d2_show;// Second dwell as shown
		logic                rear_q; // Rear contact last cycle
		logic [7:0]          p_rep;  // Permanent profile
		logic [13:0]         p_r1, p_r2, p_d1, p_d2;
		logic signed [15:0]  p_l1, p_l2;
		logic [15:0]         hband;  // Holdback band
		logic [7:0]          w_rep;  // Working copy for this pass
		logic [13:0]         w_r1, w_r2, w_d1, w_d2;
		logic signed [15:0]  w_l1, w_l2;
	} spp_st_s;

	spp_st_s st_reg;
	spp_st_s st_next;

	// Display value to accumulator scale
	function automatic logic signed [23:0] to_acc(input logic signed [15:0] v);
		to_acc = 24'(v) * spp_pkg::ACC_SCALE;
	endfunction

	// Accumulator back to display hundredths
	function automatic logic signed [15:0] from_acc(input logic signed [23:0] a);
		from_acc = 16'(a / spp_pkg::ACC_SCALE);
	endfunction

	// Magnitude of setpoint to process deviation
	function automatic logic [16:0] abs_dev(input logic signed [15:0] a, input logic signed [15:0] b);
		logic signed [16:0] d;
		d = 17'(a) - 17'(b);
		abs_dev = d[16] ? 17'(-d) : 17'(d);
	endfunction

	logic              tick;      // One hundredth of a minute elapsed
	logic              rear_rise; // Rear contact just closed
	logic              rear_fall; // Rear contact just opened
	spp_pkg::spp_cmd_e cmd;       // Winning command this cycle
	logic              cmd_rear;  // Winning command came from the rear contact
	logic [16:0]       dev;       // Current deviation
	logic              go_r2;     // Enter second ramp
	logic              go_end;    // Pass finished
	logic signed [23:0] tgt;      // Target of the active ramp
	logic signed [23:0] step;     // Ramp increment per tick

	// Next state of the whole block
	always_comb begin
		st_next   = st_reg;
		go_r2     = 1'b0;
		go_end    = 1'b0;
		tick      = (st_reg.tcnt == 27'(TICK_CYCLES - 1));
		rear_rise = rear_contact_closed & ~st_reg.rear_q;
		rear_fall = ~rear_contact_closed & st_reg.rear_q;
		dev       = abs_dev(st_reg.sp, process_value);
		tgt       = (st_reg.seg == spp_pkg::SEG_RAMP1) ? to_acc(st_reg.w_l1) : to_acc(st_reg.w_l2);
		step      = (st_reg.seg == spp_pkg::SEG_RAMP1) ? 24'({10'h000, st_reg.w_r1}) : 24'({10'h000, st_reg.w_r2});
		st_next.rear_q  = rear_contact_closed;
		st_next.refused = 1'b0;
		st_next.nv      = power_fail;
		// Free running tick divider
		st_next.tcnt = tick ? 27'h0000000 : 27'(st_reg.tcnt + 27'h0000001);
		// Flash phase divider
		if (st_reg.fcnt == 26'(FLASH_CYCLES - 1)) begin
			st_next.fcnt  = 26'h0000000;
			st_next.flash = ~st_reg.flash;
		end else begin
			st_next.fcnt = 26'(st_reg.fcnt + 26'h0000001);
		end
		// Equal priority sources, later in the chain wins the same cycle
		cmd      = spp_pkg::CMD_NONE;
		cmd_rear = 1'b0;
		if (comms_cmd_valid) begin
			cmd = comms_cmd;
		end
		if (panel_cmd_valid) begin
			// Panel run with the contact open starts and halts
			if (panel_cmd == spp_pkg::CMD_RUN && !rear_contact_closed) begin
				cmd = spp_pkg::CMD_HOLD;
			end else begin
				cmd = panel_cmd;
			end
		end
		if (rear_rise) begin
			cmd      = spp_pkg::CMD_RUN;
			cmd_rear = 1'b1;
		end else if (rear_fall) begin
			cmd      = spp_pkg::CMD_HOLD;
			cmd_rear = 1'b1;
		end
		// Parameter writes by state
		if (param_wr) begin
			if (param_sel == spp_pkg::PSEL_HBAND) begin
				st_next.hband = param_wdata;
			end else if (st_reg.state == spp_pkg::SPP_RUN || st_reg.state == spp_pkg::SPP_HOLDBACK) begin
				st_next.refused = 1'b1;
			end else begin
				case (param_sel)
					spp_pkg::PSEL_REPEAT: begin
						if (param_wdata > 16'(spp_pkg::REPEAT_MAX)) begin
							st_next.refused = 1'b1;
						end else begin
							st_next.w_rep = param_wdata[7:0];
							st_next.rep   = param_wdata[7:0];
						end
					end
					spp_pkg::PSEL_RATE1, spp_pkg::PSEL_RATE2: begin
						if (param_wdata < 16'(spp_pkg::RATE_MIN) || param_wdata > 16'(spp_pkg::RATE_MAX)) begin
							st_next.refused = 1'b1;
						end else if (param_sel == spp_pkg::PSEL_RATE1) begin
							st_next.w_r1 = param_wdata[13:0];
						end else begin
							st_next.w_r2 = param_wdata[13:0];
						end
					end
					spp_pkg::PSEL_DWELL1, spp_pkg::PSEL_DWELL2: begin
						if (param_wdata > 16'(spp_pkg::DWELL_MAX)) begin
							st_next.refused = 1'b1;
						end else if (param_sel == spp_pkg::PSEL_DWELL1) begin
							st_next.w_d1 = param_wdata[13:0];
						end else begin
							st_next.w_d2 = param_wdata[13:0];
						end
					end
					spp_pkg::PSEL_TGT1: begin
						st_next.w_l1 = param_wdata;
					end
					default: begin
						st_next.w_l2 = param_wdata;
					end
				endcase
				// Idle edits are kept; hold edits stay in the working copy
				if (st_reg.state == spp_pkg::SPP_IDLE) begin
					st_next.p_rep = st_next.w_rep;
					st_next.p_r1  = st_next.w_r1;
					st_next.p_r2  = st_next.w_r2;
					st_next.p_l1  = st_next.w_l1;
					st_next.p_l2  = st_next.w_l2;
					st_next.p_d1  = st_next.w_d1;
					st_next.p_d2  = st_next.w_d2;
				end
			end
		end
		// State machine
		case (st_reg.state)
			spp_pkg::SPP_IDLE: begin
				st_next.rep = st_next.p_rep;
				if (cmd == spp_pkg::CMD_RUN || (cmd == spp_pkg::CMD_HOLD && !cmd_rear)) begin
					// Start at ramp1 from the measured value
					st_next.state = (cmd == spp_pkg::CMD_RUN) ? spp_pkg::SPP_RUN : spp_pkg::SPP_HOLD;
					st_next.seg   = spp_pkg::SEG_RAMP1;
					st_next.acc   = to_acc(process_value);
					st_next.up    = (st_next.w_l1 > process_value);
					st_next.sub   = 7'h00;
				end
			end
			spp_pkg::SPP_HOLD: begin
				// Frozen; only commands move it
				if (cmd == spp_pkg::CMD_RUN) begin
					st_next.state = spp_pkg::SPP_RUN;
				end else if (cmd == spp_pkg::CMD_IDLE) begin
					st_next.state = spp_pkg::SPP_IDLE;
				end
			end
			default: begin
				// Run and holdback
				if (cmd == spp_pkg::CMD_IDLE) begin
					st_next.state = spp_pkg::SPP_IDLE;
				end else if (cmd == spp_pkg::CMD_HOLD) begin
					st_next.state = spp_pkg::SPP_HOLD;
				end else if (st_reg.state == spp_pkg::SPP_HOLDBACK) begin
					if (dev < 17'(st_reg.hband)) begin
						st_next.state = spp_pkg::SPP_RUN;
					end
				end else if (dev > 17'(st_reg.hband)) begin
					st_next.state = spp_pkg::SPP_HOLDBACK;
				end else if (tick) begin
					case (st_reg.seg)
						spp_pkg::SEG_RAMP1, spp_pkg::SEG_RAMP2: begin
							// Linear step, clamped at the target
							if (st_reg.up ? (st_reg.acc + step >= tgt) : (st_reg.acc - step <= tgt)) begin
								st_next.acc = tgt;
								if (st_reg.seg == spp_pkg::SEG_RAMP1) begin
									if (st_reg.w_d1 != 14'h0000) begin
										st_next.seg   = spp_pkg::SEG_DWELL1;
										st_next.dleft = st_reg.w_d1;
										st_next.sub   = 7'h00;
									end else begin
										go_r2 = 1'b1;
									end
								end else if (st_reg.w_d2 != 14'h0000) begin
									st_next.seg   = spp_pkg::SEG_DWELL2;
									st_next.dleft = st_reg.w_d2;
									st_next.sub   = 7'h00;
								end else begin
									go_end = 1'b1;
								end
							end else begin
								st_next.acc = st_reg.up ? st_reg.acc + step : st_reg.acc - step;
							end
						end
						default: begin
							// Dwell timer counts whole minutes
							if (st_reg.sub == spp_pkg::TICKS_PER_MIN - 7'h01) begin
								st_next.sub   = 7'h00;
								st_next.dleft = st_reg.dleft - 14'h0001;
								if (st_reg.dleft == 14'h0001) begin
									go_r2  = (st_reg.seg == spp_pkg::SEG_DWELL1);
									go_end = (st_reg.seg == spp_pkg::SEG_DWELL2);
								end
							end else begin
								st_next.sub = st_reg.sub + 7'h01;
							end
						end
					endcase
				end
			end
		endcase
		// Second ramp starts from the reached first target
		if (go_r2) begin
			st_next.seg = spp_pkg::SEG_RAMP2;
			st_next.up  = (to_acc(st_reg.w_l2) > st_next.acc);
		end
		// End of pass: loop back or finish
		if (go_end) begin
			if (st_reg.rep == spp_pkg::REPEAT_ENDLESS || st_reg.rep > 8'h01) begin
				st_next.seg = spp_pkg::SEG_RAMP1;
				st_next.acc = to_acc(process_value);
				st_next.up  = (st_reg.p_l1 > process_value);
				if (st_reg.rep != spp_pkg::REPEAT_ENDLESS) begin
					st_next.rep = st_reg.rep - 8'h01;
				end
			end else begin
				st_next.state = spp_pkg::SPP_IDLE;
			end
			// Hold edits to rates, targets and dwells expire with the pass
			st_next.w_r1 = st_reg.p_r1;
			st_next.w_r2 = st_reg.p_r2;
			st_next.w_l1 = st_reg.p_l1;
			st_next.w_l2 = st_reg.p_l2;
			st_next.w_d1 = st_reg.p_d1;
			st_next.w_d2 = st_reg.p_d2;
		end
		// Leaving to idle drops any temporary edits
		if (st_next.state == spp_pkg::SPP_IDLE && st_reg.state != spp_pkg::SPP_IDLE) begin
			st_next.seg   = spp_pkg::SEG_RAMP1;
			st_next.w_rep = st_reg.p_rep;
			st_next.w_r1  = st_reg.p_r1;
			st_next.w_r2  = st_reg.p_r2;
			st_next.w_l1  = st_reg.p_l1;
			st_next.w_l2  = st_reg.p_l2;
			st_next.w_d1  = st_reg.p_d1;
			st_next.w_d2  = st_reg.p_d2;
			st_next.dleft = 14'h0000;
		end
		// Recovery after power return waits in holdback
		if (resume_req) begin
			st_next.state = spp_pkg::SPP_HOLDBACK;
			st_next.seg   = resume_seg;
			st_next.acc   = to_acc(resume_setpoint);
			st_next.rep   = resume_repeat;
			st_next.dleft = resume_dwell;
			st_next.sub   = 7'h00;
			st_next.up    = (resume_seg == spp_pkg::SEG_RAMP2) ? (st_reg.w_l2 > resume_setpoint) :
				(st_reg.w_l1 > resume_setpoint);
		end
		// Setpoint handed to the control loop
		st_next.sp = (st_next.state == spp_pkg::SPP_IDLE) ? normal_control_setpoint : from_acc(st_next.acc);
		// Beacon: dark, steady, or flashing
		case (st_next.state)
			spp_pkg::SPP_IDLE: st_next.beacon = 1'b0;
			spp_pkg::SPP_RUN:  st_next.beacon = 1'b1;
			default:           st_next.beacon = st_next.flash;
		endcase
		// Dwell parameters show the minutes left while their own dwell runs
		st_next.d1_show = (st_next.state != spp_pkg::SPP_IDLE && st_next.seg == spp_pkg::SEG_DWELL1) ?
			st_next.dleft : st_next.w_d1;
		st_next.d2_show = (st_next.state != spp_pkg::SPP_IDLE && st_next.seg == spp_pkg::SEG_DWELL2) ?
			st_next.dleft : st_next.w_d2;
	end

	// State register
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_reg        <= '0;
			st_reg.state  <= spp_pkg::SPP_IDLE;
			st_reg.rear_q <= 1'b1;
			st_reg.p_rep  <= spp_pkg::RST_REPEAT;
			st_reg.w_rep  <= spp_pkg::RST_REPEAT;
			st_reg.rep    <= spp_pkg::RST_REPEAT;
			st_reg.p_r1   <= spp_pkg::RST_RATE;
			st_reg.p_r2   <= spp_pkg::RST_RATE;
			st_reg.w_r1   <= spp_pkg::RST_RATE;
			st_reg.w_r2   <= spp_pkg::RST_RATE;
			st_reg.p_l1   <= spp_pkg::RST_TGT;
			st_reg.p_l2   <= spp_pkg::RST_TGT;
			st_reg.w_l1   <= spp_pkg::RST_TGT;
			st_reg.w_l2   <= spp_pkg::RST_TGT;
			st_reg.p_d1   <= spp_pkg::RST_DWELL;
			st_reg.p_d2   <= spp_pkg::RST_DWELL;
			st_reg.w_d1   <= spp_pkg::RST_DWELL;
			st_reg.w_d2   <= spp_pkg::RST_DWELL;
			st_reg.hband  <= spp_pkg::RST_HBAND;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state flops
	assign active_setpoint   = st_reg.sp;
	assign prog_state        = st_reg.state;
	assign prog_segment      = st_reg.seg;
	assign repeat_count      = st_reg.rep;
	assign first_dwell_time  = st_reg.d1_show;
	assign second_dwell_time = st_reg.d2_show;
	assign beacon            = st_reg.beacon;
	assign param_refused     = st_reg.refused;
	assign nv_save           = st_reg.nv;

	default clocking spp_cb @(posedge mclk); endclocking
	default disable iff (srst);

	// Segment advances only forward by one or by a skipped dwell
	a_seg_order: assert property (($past(st_reg.state) == spp_pkg::SPP_RUN && st_reg.seg != $past(st_reg.seg)
		&& st_reg.state != spp_pkg::SPP_IDLE
		&& !$past(resume_req)) |-> (st_reg.seg == spp_pkg::spp_seg_e'(2'($past(st_reg.seg)) + 2'h1)
		|| st_reg.seg == spp_pkg::spp_seg_e'(2'($past(st_reg.seg)) + 2'h2)))
		else $error("segment order broken");
	a_rep_decr: assert property ((st_reg.state == spp_pkg::SPP_RUN && st_reg.seg != spp_pkg::SEG_RAMP1
		&& st_reg.rep > 8'h01 && st_next.seg == spp_pkg::SEG_RAMP1 && st_next.state == spp_pkg::SPP_RUN
		&& !resume_req) |=> (st_reg.rep == $past(st_reg.rep) - 8'h01))
		else $error("pass count not decremented");
	a_dwell_skip: assert property ((st_reg.state == spp_pkg::SPP_RUN && st_reg.seg == spp_pkg::SEG_RAMP1
		&& st_next.seg == spp_pkg::SEG_RAMP2 && !resume_req) |-> (st_reg.w_d1 == 14'h0000))
		else $error("nonzero dwell skipped");
	a_idle_setpoint: assert property ((st_reg.state == spp_pkg::SPP_IDLE && st_next.state == spp_pkg::SPP_IDLE)
		|=> (active_setpoint == $past(normal_control_setpoint)))
		else $error("idle does not use normal setpoint");
	a_start_ramp1: assert property (($past(st_reg.state) == spp_pkg::SPP_IDLE && st_reg.state != spp_pkg::SPP_IDLE
		&& !$past(resume_req)) |-> (st_reg.seg == spp_pkg::SEG_RAMP1 && st_reg.acc == to_acc($past(process_value))))
		else $error("start not at first ramp from process value");
	a_hold_freeze: assert property ((st_reg.state == spp_pkg::SPP_HOLD && !resume_req) |=> $stable(st_reg.acc))
		else $error("setpoint moved in hold");
	a_run_locked: assert property ((param_wr && param_sel != spp_pkg::PSEL_HBAND
		&& st_reg.state == spp_pkg::SPP_RUN) |=> (param_refused && $stable(st_reg.p_l1) && $stable(st_reg.w_l1)))
		else $error("profile write accepted while running");
	a_holdback_entry: assert property ((st_reg.state == spp_pkg::SPP_RUN && dev > 17'(st_reg.hband)
		&& !comms_cmd_valid && !panel_cmd_valid && !rear_rise && !rear_fall && !resume_req)
		|=> (prog_state == spp_pkg::SPP_HOLDBACK))
		else $error("holdback not entered");
	a_beacon_level: assert property (((st_reg.state == spp_pkg::SPP_RUN) |-> beacon)
		and ((st_reg.state == spp_pkg::SPP_IDLE) |-> !beacon))
		else $error("beacon wrong for state");
	a_rear_no_idle: assert property ((rear_rise || rear_fall) && st_reg.state != spp_pkg::SPP_IDLE && !resume_req
		|=> (prog_state != spp_pkg::SPP_IDLE) || $past(go_end))
		else $error("rear contact forced idle");
endmodule
`default_nettype wire

// file: hw/spp_pkg.sv
// Constants, types and timing for the setpoint profile programmer
//
// How it works
// - Segments run ramp1, dwell1, ramp2, dwell2, loop
// - Repeat count 1 to 200 or endless
// - Remaining passes count down while running
// - Ramp moves linearly up or down toward target
// - Ramp rates 0.01 to 99.99 units per minute
// - First ramp starts from measured process value
// - Dwell holds 0 to 9999 minutes, shows remaining
// - Zero dwell is skipped
// - Idle, run, hold selectable; holdback internal only
// - Idle uses normal setpoint, profile not executed
// - Run from idle starts at ramp1; ends idle
// - Idle while running abandons and resets profile
// - Hold freezes setpoint; run resumes, idle resets
// - Excess deviation pauses ramp or dwell timer
// - Three command sources, last one wins
// - Panel hold from idle starts then halts
// - Rear contact starts or halts, never idles
// - Beacon off idle, on run, flashing hold
// - Running rejects profile writes, accepts holdback band
// - Hold edits of rates, targets, dwells last one pass; idle edits permanent
// - Completion returns idle with normal setpoint
// - Position saved at power loss, resumed in band
`default_nettype none
package spp_pkg;
	// Programmer states; holdback is never selectable
	typedef enum logic [1:0] {SPP_IDLE, SPP_RUN, SPP_HOLD, SPP_HOLDBACK} spp_state_e;
	// Profile segments in execution order
	typedef enum logic [1:0] {SEG_RAMP1, SEG_DWELL1, SEG_RAMP2, SEG_DWELL2} spp_seg_e;
	// State change commands
	typedef enum logic [1:0] {CMD_NONE, CMD_IDLE, CMD_RUN, CMD_HOLD} spp_cmd_e;
	// Parameter selectors for the write port
	localparam logic [2:0] PSEL_REPEAT = 3'h0;
	localparam logic [2:0] PSEL_RATE1  = 3'h1;
	localparam logic [2:0] PSEL_TGT1   = 3'h2;
	localparam logic [2:0] PSEL_DWELL1 = 3'h3;
	localparam logic [2:0] PSEL_RATE2  = 3'h4;
	localparam logic [2:0] PSEL_TGT2   = 3'h5;
	localparam logic [2:0] PSEL_DWELL2 = 3'h6;
	localparam logic [2:0] PSEL_HBAND  = 3'h7;
	// Limits; repeat count zero means endless
	localparam logic [7:0]  REPEAT_ENDLESS = 8'h00;
	localparam logic [7:0]  REPEAT_MAX     = 8'hc8;
	localparam logic [13:0] RATE_MIN       = 14'h0001;
	localparam logic [13:0] RATE_MAX       = 14'h270f;
	localparam logic [13:0] DWELL_MAX      = 14'h270f;
	// Reset values of the stored profile
	localparam logic [7:0]  RST_REPEAT = 8'h01;
	localparam logic [13:0] RST_RATE   = 14'h0064;
	localparam logic [15:0] RST_TGT    = 16'h0000;
	localparam logic [13:0] RST_DWELL  = 14'h0000;
	localparam logic [15:0] RST_HBAND  = 16'h7fff;
	// Accumulator carries two extra decimal digits below setpoint hundredths
	localparam logic signed [23:0] ACC_SCALE = 24'sh000064;
	// Tick of one hundredth of a minute
	localparam longint CLK_PERIOD_PS   = 5000;
	localparam longint TICK_TIME_MS    = 600;
	localparam int     TICK_CYCLES     = int'((TICK_TIME_MS * 1000000000) / CLK_PERIOD_PS);
	localparam logic [6:0] TICKS_PER_MIN = 7'h64;
	// Beacon flash half period
	localparam longint FLASH_TIME_MS   = 250;
	localparam int     FLASH_CYCLES    = int'((FLASH_TIME_MS * 1000000000) / CLK_PERIOD_PS);
endpackage
`default_nettype wire

// file: verif/spp_process_model.sv
// Process model standing in for the plant seen through the control algorithm
`timescale 1ns/1ps
`default_nettype none
module spp_process_model (
	input  wire logic               mclk,
	input  wire logic               srst,
	input  wire logic               track,
	input  wire logic signed [15:0] active_setpoint,
	output logic signed [15:0]      process_value
);
	// Follows the setpoint one cycle late; stalls when not tracking, which provokes holdback
	always_ff @(posedge mclk) begin
		if (srst) begin
			process_value <= 16'sh0100;
		end else if (track) begin
			process_value <= active_setpoint;
		end
	end
endmodule
`default_nettype wire

// file: verif/spp_programmer_tb.sv
// Self-checking testbench for the setpoint profile programmer
`timescale 1ns/1ps
`default_nettype none
module spp_programmer_tb;
	typedef struct {logic [2:0] sel; logic [15:0] data; logic refused;} spp_row_s;
	logic                mclk, srst, track, c_v, p_v, rear, wr, pf, rq;
	logic signed [15:0]  pv, sp, held;
	logic signed [15:0]  nsp = 16'sh0050;
	spp_pkg::spp_cmd_e   c_cmd, p_cmd;
	logic [2:0]          sel;
	logic [15:0]         wdata;
	spp_pkg::spp_state_e st;
	spp_pkg::spp_seg_e   seg;
	logic [7:0]          rep;
	logic [13:0]         d1, d2;
	logic                beacon, refused, nv_save;
	int                  mismatches, num_checks, n;
	spp_row_s            rows [12];
	// Short ticks and flashes keep the run brief
	spp_programmer #(.TICK_CYCLES(4), .FLASH_CYCLES(4)) dut (.mclk(mclk), .srst(srst), .process_value(pv),
		.normal_control_setpoint(nsp), .comms_cmd_valid(c_v), .comms_cmd(c_cmd), .panel_cmd_valid(p_v),
		.panel_cmd(p_cmd), .rear_contact_closed(rear), .param_wr(wr), .param_sel(sel), .param_wdata(wdata),
		.power_fail(pf), .resume_req(rq), .resume_seg(spp_pkg::SEG_DWELL1), .resume_setpoint(16'sh0050),
		.resume_repeat(8'h01), .resume_dwell(14'h0001), .active_setpoint(sp), .prog_state(st),
		.prog_segment(seg), .repeat_count(rep), .first_dwell_time(d1), .second_dwell_time(d2),
		.beacon(beacon), .param_refused(refused), .nv_save(nv_save));
	spp_process_model plant (.mclk(mclk), .srst(srst), .track(track), .active_setpoint(sp), .process_value(pv));
	// Free-running clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic cyc(input int k);
		repeat (k) @(negedge mclk);
	endtask
	// Value comparison
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// State comparison
	task automatic chk_st(input spp_pkg::spp_state_e exp);
		num_checks++;
		if (st !== exp) begin
			mismatches++;
			$display("unexpected at %0t: state %h expected %h", $time, st, exp);
		end
	endtask
	// One idle edge, then a one-cycle command pulse from comms (0) or panel (1)
	task automatic send(input int src, input spp_pkg::spp_cmd_e c);
		cyc(1);
		c_cmd = c;
		p_cmd = c;
		c_v = (src == 0);
		p_v = (src == 1);
		cyc(1);
		c_v = 1'b0;
		p_v = 1'b0;
	endtask
	// One idle edge, then a one-cycle parameter write; the refusal flag is settled on return
	task automatic put(input logic [2:0] s, input logic [15:0] d);
		cyc(1);
		sel = s;
		wdata = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
	endtask
	task automatic wait_st(input spp_pkg::spp_state_e e, input int lim);
		for (n = 0; n < lim && st !== e; n++) cyc(1);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Watchdog against hangs
	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		complete_run();
	end
	// Main sequence
	initial begin
		{srst, track, c_v, p_v, rear, wr, pf, rq} = 8'hc8;
		{c_cmd, p_cmd, sel, wdata} = '0;
		rows = '{'{3'h0, 16'h00c9, 1'b1}, '{3'h0, 16'h0000, 1'b0}, '{3'h0, 16'h0002, 1'b0},
			'{3'h1, 16'h0000, 1'b1},
			'{3'h1, 16'h2710, 1'b1}, '{3'h1, 16'h270f, 1'b0}, '{3'h4, 16'h270f, 1'b0},
			'{3'h3, 16'h2710, 1'b1}, '{3'h3, 16'h0001, 1'b0}, '{3'h6, 16'h0000, 1'b0},
			'{3'h2, 16'h0100, 1'b0}, '{3'h5, 16'h0100, 1'b0}};
		cyc(10);
		srst = 1'b0;
		cyc(2);
		chk_st(spp_pkg::SPP_IDLE);
		chk(sp, nsp);
		chk(beacon, 1'b0);
		$display("done: reset");
		// Idle writes, limits of repeat, rate1 and dwell1, accepted values for the rest
		foreach (rows[i]) begin
			put(rows[i].sel, rows[i].data);
			chk(refused, rows[i].refused);
		end
		chk(d1, 14'h0001);
		chk(rep, 8'h02);
		chk(d2, 14'h0000);
		$display("done: idle writes");
		send(1, spp_pkg::CMD_RUN);
		chk_st(spp_pkg::SPP_RUN);
		chk(seg, spp_pkg::SEG_RAMP1);
		chk(sp, pv);
		chk(beacon, 1'b1);
		put(spp_pkg::PSEL_RATE1, 16'h0010);
		chk(refused, 1'b1);
		put(spp_pkg::PSEL_HBAND, 16'h7fff);
		chk(refused, 1'b0);
		for (n = 0; n < 200 && seg !== spp_pkg::SEG_DWELL1; n++) cyc(1);
		chk(seg, spp_pkg::SEG_DWELL1);
		chk(d1, 14'h0001);
		send(0, spp_pkg::CMD_HOLD);
		chk_st(spp_pkg::SPP_HOLD);
		held = sp;
		put(spp_pkg::PSEL_DWELL1, 16'h0003);
		chk(refused, 1'b0);
		cyc(20);
		chk(sp, held);
		send(0, spp_pkg::CMD_RUN);
		chk_st(spp_pkg::SPP_RUN);
		for (n = 0; n < 600 && seg !== spp_pkg::SEG_RAMP1; n++) cyc(1);
		chk(rep, 8'h01);
		chk(d1, 14'h0001);
		wait_st(spp_pkg::SPP_IDLE, 600);
		chk_st(spp_pkg::SPP_IDLE);
		cyc(2);
		chk(sp, nsp);
		$display("done: profile");
		rear = 1'b0;
		cyc(2);
		chk_st(spp_pkg::SPP_IDLE);
		send(1, spp_pkg::CMD_RUN);
		chk_st(spp_pkg::SPP_HOLD);
		rear = 1'b1;
		cyc(1);
		chk_st(spp_pkg::SPP_RUN);
		rear = 1'b0;
		cyc(1);
		chk_st(spp_pkg::SPP_HOLD);
		send(1, spp_pkg::CMD_IDLE);
		chk_st(spp_pkg::SPP_IDLE);
		rear = 1'b1;
		cyc(1);
		chk_st(spp_pkg::SPP_RUN);
		send(1, spp_pkg::CMD_IDLE);
		send(1, spp_pkg::CMD_HOLD);
		chk_st(spp_pkg::SPP_HOLD);
		send(0, spp_pkg::CMD_IDLE);
		chk_st(spp_pkg::SPP_IDLE);
		$display("done: commands");
		put(spp_pkg::PSEL_HBAND, 16'h0005);
		put(spp_pkg::PSEL_TGT1, 16'h1000);
		track = 1'b0;
		send(1, spp_pkg::CMD_RUN);
		wait_st(spp_pkg::SPP_HOLDBACK, 100);
		chk_st(spp_pkg::SPP_HOLDBACK);
		track = 1'b1;
		wait_st(spp_pkg::SPP_RUN, 50);
		chk_st(spp_pkg::SPP_RUN);
		send(1, spp_pkg::CMD_IDLE);
		cyc(3);
		pf = 1'b1;
		cyc(1);
		pf = 1'b0;
		chk(nv_save, 1'b1);
		rq = 1'b1;
		cyc(1);
		rq = 1'b0;
		chk_st(spp_pkg::SPP_HOLDBACK);
		wait_st(spp_pkg::SPP_RUN, 20);
		chk_st(spp_pkg::SPP_RUN);
		$display("done: holdback and recovery");
		complete_run();
	end
endmodule
`default_nettype wire
